// >>> hcp_top.sv
// six-step hall commutation with pi speed loop and complementary pwm
`timescale 1ns/1ps
module hcp_top (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    // control
    input  wire logic                     run_en,
    input  wire logic signed [15:0]       speed_req,
    input  wire logic signed [15:0]       speed_meas,
    input  wire logic [7:0]               gain_p,
    input  wire logic [7:0]               gain_i,
    // hall sensors
    input  wire hcp_pkg::hcp_hall_t       hall,
    // power stage
    output hcp_pkg::hcp_sw_t              sw_r,
    // status
    output logic [7:0]                    duty_r,
    output logic                          hall_fault_r
);

    // ******************************
    // pwm carrier
    // ******************************
    logic pwm_on;
    logic sample_en;

    hcp_pwm_gen u_pwm (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .duty     (duty_r),
        .pwm_on_r (pwm_on),
        .period_r (sample_en)
    );

    // ******************************
    // pi speed controller
    // ******************************
    logic signed [16:0] err;
    logic signed [25:0] prod_p;
    logic signed [25:0] prod_i;
    logic signed [27:0] ui_sum;
    logic signed [27:0] u_sum;
    logic [7:0]         ui_r;
    logic [7:0]         ui_nxt;
    logic [7:0]         duty_nxt;

    function automatic logic [7:0] sat8(input logic signed [27:0] v);
        if (v < 28'sd0) begin
            return hcp_pkg::DUTY_MIN;
        end else if (v > 28'sd255) begin
            return hcp_pkg::DUTY_MAX;
        end else begin
            return v[7:0];
        end
    endfunction

    always_comb begin
        err    = 17'(speed_req) - 17'(speed_meas);
        prod_p = err * $signed({1'b0, gain_p});
        prod_i = err * $signed({1'b0, gain_i});
        ui_sum = 28'($signed({1'b0, ui_r}))
               + 28'(prod_i >>> hcp_pkg::GAIN_FRAC);
        ui_nxt = sat8(ui_sum);
        u_sum  = 28'(prod_p >>> hcp_pkg::GAIN_FRAC)
               + 28'($signed({1'b0, ui_nxt}));
        duty_nxt = sat8(u_sum);
    end

    // integral clears while stopped so a restart begins from zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ui_r   <= hcp_pkg::DUTY_RST;
            duty_r <= hcp_pkg::DUTY_RST;
        end else if (!run_en) begin
            ui_r   <= hcp_pkg::DUTY_RST;
            duty_r <= hcp_pkg::DUTY_RST;
        end else if (sample_en) begin
            ui_r   <= ui_nxt;
            duty_r <= duty_nxt;
        end
    end

    // ******************************
    // hall decode and commutation
    // ******************************
    hcp_pkg::hcp_phase_t hi_ph;
    hcp_pkg::hcp_phase_t lo_ph;
    logic                hall_bad;
    hcp_pkg::hcp_sw_t    sw_nxt;

    always_comb begin
        hall_bad = 1'b0;
        unique case ({hall.a, hall.b, hall.c})
            hcp_pkg::HALL_110: begin
                hi_ph = hcp_pkg::PH_A;
                lo_ph = hcp_pkg::PH_C;
            end
            hcp_pkg::HALL_100: begin
                hi_ph = hcp_pkg::PH_B;
                lo_ph = hcp_pkg::PH_C;
            end
            hcp_pkg::HALL_101: begin
                hi_ph = hcp_pkg::PH_B;
                lo_ph = hcp_pkg::PH_A;
            end
            hcp_pkg::HALL_001: begin
                hi_ph = hcp_pkg::PH_C;
                lo_ph = hcp_pkg::PH_A;
            end
            hcp_pkg::HALL_011: begin
                hi_ph = hcp_pkg::PH_C;
                lo_ph = hcp_pkg::PH_B;
            end
            hcp_pkg::HALL_010: begin
                hi_ph = hcp_pkg::PH_A;
                lo_ph = hcp_pkg::PH_B;
            end
            default: begin
                hi_ph    = hcp_pkg::PH_NONE;
                lo_ph    = hcp_pkg::PH_NONE;
                hall_bad = 1'b1;
            end
        endcase
    end

    // bipolar: pair swaps polarity in the pwm off time, no dead time here
    always_comb begin
        sw_nxt = hcp_pkg::SW_OFF;
        if (run_en && !hall_bad) begin
            sw_nxt.phase_a_high_switch = (hi_ph == hcp_pkg::PH_A) ? pwm_on
                : (lo_ph == hcp_pkg::PH_A) & !pwm_on;
            sw_nxt.phase_a_low_switch  = (hi_ph == hcp_pkg::PH_A) ? !pwm_on
                : (lo_ph == hcp_pkg::PH_A) & pwm_on;
            sw_nxt.phase_b_high_switch = (hi_ph == hcp_pkg::PH_B) ? pwm_on
                : (lo_ph == hcp_pkg::PH_B) & !pwm_on;
            sw_nxt.phase_b_low_switch  = (hi_ph == hcp_pkg::PH_B) ? !pwm_on
                : (lo_ph == hcp_pkg::PH_B) & pwm_on;
            sw_nxt.phase_c_high_switch = (hi_ph == hcp_pkg::PH_C) ? pwm_on
                : (lo_ph == hcp_pkg::PH_C) & !pwm_on;
            sw_nxt.phase_c_low_switch  = (hi_ph == hcp_pkg::PH_C) ? !pwm_on
                : (lo_ph == hcp_pkg::PH_C) & pwm_on;
        end
    end

    // registered straight from the hall lines: one cycle to commutate
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sw_r         <= hcp_pkg::SW_OFF;
            hall_fault_r <= 1'b0;
        end else begin
            sw_r         <= sw_nxt;
            hall_fault_r <= hall_bad;
        end
    end

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    logic [2:0] drv_ph;
    logic       hall_ok;
    logic       pair_ac;
    assign drv_ph  = {sw_r.phase_a_high_switch | sw_r.phase_a_low_switch,
                      sw_r.phase_b_high_switch | sw_r.phase_b_low_switch,
                      sw_r.phase_c_high_switch | sw_r.phase_c_low_switch};
    assign hall_ok = !hall_bad && run_en;
    assign pair_ac = sw_r.phase_a_high_switch == sw_r.phase_c_low_switch;

    property p_two_phases;
        hall_ok |=> $countones(drv_ph) == 2;
    endproperty
    a_two_phases: assert property (p_two_phases)
        else $error("driven phase count is not two");

    property p_compl;
        hall_ok |=> (sw_r.phase_a_high_switch ^ sw_r.phase_a_low_switch)
            == drv_ph[2] && !(sw_r.phase_b_high_switch
            && sw_r.phase_b_low_switch);
    endproperty
    a_compl: assert property (p_compl)
        else $error("driven phase switches not complementary");

    property p_decode;
        hall_ok && $past(hall_ok) && $stable({hall.a, hall.b, hall.c})
            |=> $stable(drv_ph);
    endproperty
    a_decode: assert property (p_decode)
        else $error("drive pattern moved with a steady hall state");

    property p_state_110;
        run_en && {hall.a, hall.b, hall.c} == hcp_pkg::HALL_110
            |=> drv_ph == 3'h5 && pair_ac
            && sw_r.phase_a_high_switch == $past(pwm_on);
    endproperty
    a_state_110: assert property (p_state_110)
        else $error("state 110 pattern wrong");

    sequence s_edge_110_100;
        {hall.a, hall.b, hall.c} == hcp_pkg::HALL_110 && run_en
        ##1 {hall.a, hall.b, hall.c} == hcp_pkg::HALL_100 && run_en;
    endsequence
    property p_new_pattern;
        s_edge_110_100 |=> drv_ph == 3'h3;
    endproperty
    a_new_pattern: assert property (p_new_pattern)
        else $error("new hall state pattern not applied");

    property p_edge_latency;
        hall_ok && $changed({hall.a, hall.b, hall.c}) && $past(hall_ok)
            |=> $changed(drv_ph);
    endproperty
    a_edge_latency: assert property (p_edge_latency)
        else $error("commutation missed a hall edge");

    property p_err_sign;
        run_en && sample_en && err >= 17'sd16 && gain_i != 8'h00
            && gain_p == 8'h00 && ui_r != hcp_pkg::DUTY_MAX
            ##1 run_en |-> ui_r > $past(ui_r) && duty_r == ui_r;
    endproperty
    a_err_sign: assert property (p_err_sign)
        else $error("positive error did not raise duty");

    property p_integral;
        run_en && sample_en && gain_i == 8'h00 ##1 run_en
            |-> $stable(ui_r);
    endproperty
    a_integral: assert property (p_integral)
        else $error("integral moved with zero integral gain");

    property p_invalid_off;
        hall_bad |=> sw_r == hcp_pkg::SW_OFF && hall_fault_r;
    endproperty
    a_invalid_off: assert property (p_invalid_off)
        else $error("switches on during invalid hall state");

    property p_no_windup;
        run_en && sample_en && err <= -17'sd16 && gain_i != 8'h00
            && ui_r == hcp_pkg::DUTY_MAX ##1 run_en
            |-> ui_r < $past(ui_r);
    endproperty
    a_no_windup: assert property (p_no_windup)
        else $error("integral wound past limit");

endmodule

// >>> hcp_pkg.sv
// shared constants and types for the hall commutation speed loop
package hcp_pkg;

    // ******************************
    // widths
    // ******************************
    localparam int SPEED_W   = 16;
    localparam int GAIN_W    = 8;
    localparam int DUTY_W    = 8;
    localparam int GAIN_FRAC = 4;
    localparam int ACC_W     = 28;

    // ******************************
    // reset values and limits
    // ******************************
    localparam logic [7:0] DUTY_MIN = 8'h00;
    localparam logic [7:0] DUTY_MAX = 8'hFF;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] CNT_RST  = 8'h00;
    localparam logic [7:0] CNT_LAST = 8'hFF;

    // ******************************
    // hall codes, order a-b-c
    // ******************************
    localparam logic [2:0] HALL_110 = 3'h6;
    localparam logic [2:0] HALL_100 = 3'h4;
    localparam logic [2:0] HALL_101 = 3'h5;
    localparam logic [2:0] HALL_001 = 3'h1;
    localparam logic [2:0] HALL_011 = 3'h3;
    localparam logic [2:0] HALL_010 = 3'h2;

    typedef enum logic [2:0] {
        PH_NONE = 3'h0,
        PH_A    = 3'h1,
        PH_B    = 3'h2,
        PH_C    = 3'h4
    } hcp_phase_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } hcp_hall_t;

    typedef struct packed {
        logic phase_a_high_switch;
        logic phase_a_low_switch;
        logic phase_b_high_switch;
        logic phase_b_low_switch;
        logic phase_c_high_switch;
        logic phase_c_low_switch;
    } hcp_sw_t;

    localparam hcp_sw_t SW_OFF = 6'h00;

endpackage

// >>> hcp_pwm_gen.sv
// free running pwm carrier with duty compare and period pulse
`timescale 1ns/1ps
module hcp_pwm_gen (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              srst,
    // duty in
    input  wire logic [7:0]        duty,
    // carrier out
    output logic                   pwm_on_r,
    output logic                   period_r
);

    logic [7:0] cnt_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_r <= hcp_pkg::CNT_RST;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // duty of full scale gives 255/256 on time
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwm_on_r <= 1'b0;
            period_r <= 1'b0;
        end else begin
            pwm_on_r <= (cnt_r < duty);
            period_r <= (cnt_r == hcp_pkg::CNT_LAST);
        end
    end

endmodule

// >>> hcp_motor_model.sv
// hall sensor source and inverter leg watcher
`timescale 1ns/1ps
module hcp_motor_model (
    // clock
    input  wire logic              sys_clk,
    // rotor position in, sensors out
    input  wire logic [2:0]        pos,
    output hcp_pkg::hcp_hall_t     hall,
    // power stage
    input  wire hcp_pkg::hcp_sw_t  sw,
    output logic                   shoot
);
    logic [2:0] code;

    // positions 6 and 7 stand for broken sensor wiring
    always_comb begin
        case (pos)
            3'h0:    code = hcp_pkg::HALL_110;
            3'h1:    code = hcp_pkg::HALL_100;
            3'h2:    code = hcp_pkg::HALL_101;
            3'h3:    code = hcp_pkg::HALL_001;
            3'h4:    code = hcp_pkg::HALL_011;
            3'h5:    code = hcp_pkg::HALL_010;
            3'h6:    code = 3'h0;
            default: code = 3'h7;
        endcase
    end
    assign hall = hcp_pkg::hcp_hall_t'(code);

    // both switches of one leg on would short the bus
    always_ff @(posedge sys_clk) begin
        shoot <= (sw.phase_a_high_switch & sw.phase_a_low_switch)
               | (sw.phase_b_high_switch & sw.phase_b_low_switch)
               | (sw.phase_c_high_switch & sw.phase_c_low_switch);
    end
endmodule

// >>> hall_commutation_pi_speed_tb.sv
// self-checking bench for the hall commutation speed loop
`timescale 1ns/1ps
module hall_commutation_pi_speed_tb;
    logic                    sys_clk = 1'b0;
    logic                    srst    = 1'b1;
    logic                    run_en  = 1'b0;
    logic signed [15:0]      speed_req  = 16'h0000;
    logic signed [15:0]      speed_meas = 16'h0000;
    logic [7:0]              gain_p  = 8'h10;
    logic [7:0]              gain_i  = 8'h00;
    logic [2:0]              pos     = 3'h0;
    hcp_pkg::hcp_hall_t      hall;
    hcp_pkg::hcp_sw_t        sw_r;
    logic [7:0]              duty_r;
    logic                    hall_fault_r;
    logic                    shoot;
    int                      error_cnt = 0;
    int                      n_tests   = 0;

    // on and off halves of each position's phase pair, a_hi..c_lo
    localparam logic [5:0] ON_P [6]  = '{6'h21, 6'h09, 6'h18,
                                         6'h12, 6'h06, 6'h24};
    localparam logic [5:0] OFF_P [6] = '{6'h12, 6'h06, 6'h24,
                                         6'h21, 6'h09, 6'h18};

    always #50 sys_clk = ~sys_clk;

    hcp_top uut (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .run_en       (run_en),
        .speed_req    (speed_req),
        .speed_meas   (speed_meas),
        .gain_p       (gain_p),
        .gain_i       (gain_i),
        .hall         (hall),
        .sw_r         (sw_r),
        .duty_r       (duty_r),
        .hall_fault_r (hall_fault_r)
    );

    hcp_motor_model model (
        .sys_clk (sys_clk),
        .pos     (pos),
        .hall    (hall),
        .sw      (sw_r),
        .shoot   (shoot)
    );

    // ******************************
    // helpers
    // ******************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset();
        srst = 1'b1;
        tick(2);
        check({2'h0, sw_r}, 8'h00);
        check(duty_r, 8'h00);
        check({7'h00, hall_fault_r}, 8'h00);
        srst = 1'b0;
    endtask

    // integral grows by the error each sample, clips, then falls at once
    task automatic t_integral();
        speed_req = 16'sd100;
        gain_p    = 8'h00;
        gain_i    = 8'h10;
        run_en    = 1'b1;
        tick(300);
        check(duty_r, 8'h64);
        tick(256);
        check(duty_r, 8'hC8);
        tick(256);
        check(duty_r, 8'hFF);
        speed_meas = 16'sd200;
        tick(256);
        check(duty_r, 8'h9B);
        run_en = 1'b0;
        tick(3);
        check(duty_r, 8'h00);
        check({2'h0, sw_r}, 8'h00);
    endtask

    task automatic t_prop();
        gain_p     = 8'h10;
        gain_i     = 8'h00;
        speed_req  = 16'sd0;
        speed_meas = 16'sd100;
        run_en     = 1'b1;
        tick(300);
        check(duty_r, 8'h00);
        speed_req  = 16'sd64;
        speed_meas = 16'sd0;
        tick(300);
        check(duty_r, 8'h40);
    endtask

    // each of the six valid positions over a whole carrier period at quarter duty
    task automatic t_table();
        int n_on;
        for (int p = 0; p < 6; p++) begin
            pos = 3'(p);
            tick(2);
            n_on = 0;
            for (int c = 0; c < 256; c++) begin
                check({2'h0, sw_r}, sw_r === ON_P[p] ? ON_P[p] : OFF_P[p]);
                check({7'h00, shoot}, 8'h00);
                if (sw_r === ON_P[p])
                    n_on++;
                tick(1);
            end
            check(8'(n_on), 8'h40);
        end
    endtask

    task automatic t_change();
        pos = 3'h0;
        tick(3);
        pos = 3'h1;
        tick(2);
        check({2'h0, sw_r}, sw_r === ON_P[1] ? ON_P[1] : OFF_P[1]);
    endtask

    task automatic t_fault();
        for (int p = 6; p < 8; p++) begin
            pos = 3'(p);
            tick(2);
            check({2'h0, sw_r}, 8'h00);
            check({7'h00, hall_fault_r}, 8'h01);
        end
        pos = 3'h0;
        tick(2);
        check({7'h00, hall_fault_r}, 8'h00);
        check({2'h0, sw_r}, sw_r === ON_P[0] ? ON_P[0] : OFF_P[0]);
    endtask

    initial begin
        tick(1);
        t_reset();
        t_integral();
        t_prop();
        t_table();
        t_change();
        t_fault();
        t_reset();
        give_verdict();
    end
endmodule
